// ### src/pep_host.sv
/*
 Host controller for a byte-wide paged EEPROM: drives chip select, output
 gate, write strobe, address and the two-way data byte. Reads return data
 through a two-entry buffer. Page writes, lock and unlock commands are
 issued, and the end of programming is found by polling the top data bit.
 Assumes the memory is clockless and that requests come from same-clock logic.
*/
// What this block does
// - Keep page bits fixed within page load; this block only flags a change on page_error.
// - Gate stays high while writing strobes low.
// - Next byte within 150 us window.
// - Three prefix bytes, exact address and order.
// - One to 256 data bytes per page load; this block does not count them.
`timescale 1ns/10ps
`default_nettype none
module pep_host #(
   parameter int BLC_CYCLES = pep_pkg::BLC_CYC,
   parameter int WC_CYCLES = pep_pkg::WC_CYC
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Request port: op, address, write data, last byte of the page.
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [1:0] req_op,
   input wire logic [pep_pkg::ADDR_W-1:0] req_addr,
   input wire logic [pep_pkg::DATA_W-1:0] req_wdata,
   input wire logic req_last,
   // Read data out.
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [pep_pkg::DATA_W-1:0] rd_data,
   // Status.
   output logic busy,
   output logic prog_done,
   output logic page_error,
   // Memory pins.
   output logic chip_sel_n,
   output logic out_gate_n,
   output logic wr_strobe_n,
   output logic [pep_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [pep_pkg::DATA_W-1:0] mem_data_in,
   output logic [pep_pkg::DATA_W-1:0] mem_data_out,
   output logic mem_data_oe
);
   pep_pkg::pep_state_t st_q, st_d;
   logic cs_q, oe_q, we_q, doe_q, busy_q, done_q, perr_q, inpage_q, cmd_q;
   logic [pep_pkg::ADDR_W-1:0] a_q;
   logic [pep_pkg::DATA_W-1:0] d_q, last_d_q, sync1_q, sync2_q;
   logic [pep_pkg::CNT_W-1:0] t_q, wc_q;
   logic [1:0] pre_q, op_q;
   localparam int PAGE_LO_W = pep_pkg::PAGE_LO;
   // Cycles kept in hand before the byte window closes.
   localparam int BLC_MARGIN = 8;
   logic [pep_pkg::ADDR_W-PAGE_LO_W-1:0] page_q;
   logic fin_q;
   // The request is kept apart, since the command prefix borrows the pins.
   logic [pep_pkg::ADDR_W-1:0] ra_q;
   logic [pep_pkg::DATA_W-1:0] wd_q, rdat_q;
   logic buf_in_valid, buf_in_ready;

   // Prefix byte selection for lock, unlock and protected writes.
   function automatic logic [pep_pkg::CMD_ADDR_W-1:0] pre_addr(input logic [1:0] i);
      pre_addr = (i == 2'h0) ? pep_pkg::CMD_A0 : (i == 2'h1) ? pep_pkg::CMD_A1
         : pep_pkg::CMD_A2;
   endfunction : pre_addr
   function automatic logic [pep_pkg::DATA_W-1:0] pre_data(input logic [1:0] i,
      input logic [1:0] op);
      pre_data = (i == 2'h0) ? pep_pkg::CMD_D0 : (i == 2'h1) ? pep_pkg::CMD_D1
         : (op == pep_pkg::OP_UNLOCK) ? pep_pkg::CMD_UNLOCK_D3 : pep_pkg::CMD_LOCK;
   endfunction : pre_data

   // Decoded conditions.
   wire take = req_valid && req_ready;
   wire t_zero = (t_q == '0);
   wire [pep_pkg::DATA_W-1:0] pin_d = sync2_q;
   wire poll_match = (rdat_q[pep_pkg::POLL_BIT] == last_d_q[pep_pkg::POLL_BIT]);
   wire same_page = (req_addr[pep_pkg::ADDR_W-1:PAGE_LO_W] == page_q);
   wire blc_expired = inpage_q && (wc_q >= pep_pkg::CNT_W'(BLC_CYCLES - BLC_MARGIN));
   // Another byte follows: lock and unlock stop after three prefix bytes, a write opening a page sends three prefix bytes then data.
   wire more_pre = cmd_q && ((pre_q < 2'h2) || (pre_q == 2'h2 && op_q == pep_pkg::OP_WRITE));
   wire wc_over = (wc_q >= pep_pkg::CNT_W'(WC_CYCLES));

   // Ready only in idle and only when the read buffer has room, so a stall
   // by the reader holds off new requests rather than losing a byte.
   assign req_ready = (st_q == pep_pkg::ST_IDLE) && buf_in_ready && !blc_expired;
   assign buf_in_valid = (st_q == pep_pkg::ST_RD_FLOAT) && t_zero;

   // Next state.
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         pep_pkg::ST_IDLE:
            if (take)
               st_d = (req_op == pep_pkg::OP_READ) ? pep_pkg::ST_RD_WAIT
                  : pep_pkg::ST_WR_SETUP;
            else if (blc_expired || (fin_q && inpage_q))
               st_d = pep_pkg::ST_POLL_RD;
         pep_pkg::ST_RD_WAIT: if (t_zero) st_d = pep_pkg::ST_RD_FLOAT;
         pep_pkg::ST_RD_FLOAT: if (t_zero) st_d = pep_pkg::ST_IDLE;
         pep_pkg::ST_WR_SETUP: st_d = pep_pkg::ST_WR_LOW;
         pep_pkg::ST_WR_LOW: if (t_zero) st_d = pep_pkg::ST_WR_HIGH;
         pep_pkg::ST_WR_HIGH:
            if (t_zero)
               st_d = more_pre ? pep_pkg::ST_WR_SETUP : pep_pkg::ST_IDLE;
         pep_pkg::ST_POLL_RD: if (t_zero) st_d = pep_pkg::ST_POLL_FLOAT;
         pep_pkg::ST_POLL_FLOAT:
            if (t_zero)
               st_d = (poll_match || wc_over) ? pep_pkg::ST_DONE : pep_pkg::ST_POLL_RD;
         pep_pkg::ST_DONE: st_d = pep_pkg::ST_IDLE;
         default: st_d = pep_pkg::ST_IDLE;
      endcase
   end

   // Pin sync: data pins are asynchronous and pass two flops first.
   always_ff @(posedge clk)
   begin
      sync1_q <= mem_data_in;
      sync2_q <= sync1_q;
   end

   // Main sequencer.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_q <= pep_pkg::ST_IDLE;
         cs_q <= 1'b1;
         oe_q <= 1'b1;
         we_q <= 1'b1;
         doe_q <= 1'b0;
         a_q <= '0;
         d_q <= '0;
         ra_q <= '0;
         wd_q <= '0;
         rdat_q <= '0;
         last_d_q <= '0;
         t_q <= '0;
         wc_q <= '0;
         pre_q <= 2'h0;
         op_q <= pep_pkg::OP_READ;
         cmd_q <= 1'b0;
         page_q <= '0;
         inpage_q <= 1'b0;
         fin_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         perr_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         done_q <= 1'b0;
         t_q <= t_zero ? t_q : t_q - 1'b1;
         wc_q <= inpage_q || (st_q == pep_pkg::ST_POLL_RD) || (st_q == pep_pkg::ST_POLL_FLOAT)
            ? wc_q + 1'b1 : wc_q;
         case (st_q)
            pep_pkg::ST_IDLE:
               if (take)
               begin
                  op_q <= req_op;
                  a_q <= req_addr;
                  d_q <= req_wdata;
                  ra_q <= req_addr;
                  wd_q <= req_wdata;
                  fin_q <= req_last || (req_op != pep_pkg::OP_WRITE);
                  busy_q <= 1'b1;
                  cmd_q <= (req_op != pep_pkg::OP_READ) && !inpage_q;
                  pre_q <= 2'h0;
                  perr_q <= inpage_q && !same_page;
                  if (req_op == pep_pkg::OP_READ)
                  begin
                     cs_q <= 1'b0;
                     oe_q <= 1'b0;
                     t_q <= pep_pkg::CNT_W'(pep_pkg::ACC_CYC + 2);
                  end
                  else if (!inpage_q)
                     page_q <= req_addr[pep_pkg::ADDR_W-1:PAGE_LO_W];
               end
               else if (blc_expired || (fin_q && inpage_q))
               begin
                  // Stop loading; the device starts programming on its own.
                  inpage_q <= 1'b0;
                  busy_q <= 1'b1;
                  wc_q <= '0;
                  cs_q <= 1'b0;
                  oe_q <= 1'b0;
                  t_q <= pep_pkg::CNT_W'(pep_pkg::ACC_CYC + 2);
               end
            pep_pkg::ST_RD_WAIT:
               if (t_zero)
               begin
                  // Take the byte before the lines float and go stale.
                  rdat_q <= pin_d;
                  cs_q <= 1'b1;
                  oe_q <= 1'b1;
                  t_q <= pep_pkg::CNT_W'(pep_pkg::DF_CYC);
               end
            pep_pkg::ST_RD_FLOAT:
               if (t_zero)
                  busy_q <= 1'b0;
            pep_pkg::ST_WR_SETUP:
            begin
               // Gate high before select and strobe fall.
               oe_q <= 1'b1;
               doe_q <= 1'b1;
               if (cmd_q && pre_q != 2'h3)
               begin
                  a_q <= {{(pep_pkg::ADDR_W-pep_pkg::CMD_ADDR_W){1'b0}}, pre_addr(pre_q)};
                  d_q <= pre_data(pre_q, op_q);
               end
               else
               begin
                  a_q <= ra_q;
                  d_q <= wd_q;
               end
               cs_q <= 1'b0;
               we_q <= 1'b0;
               t_q <= pep_pkg::CNT_W'(pep_pkg::WP_CYC);
            end
            pep_pkg::ST_WR_LOW:
               if (t_zero)
               begin
                  we_q <= 1'b1;
                  cs_q <= 1'b1;
                  t_q <= pep_pkg::CNT_W'(pep_pkg::WPH_CYC);
               end
            pep_pkg::ST_WR_HIGH:
               if (t_zero)
               begin
                  doe_q <= 1'b0;
                  inpage_q <= 1'b1;
                  wc_q <= '0; // Window restarts with each byte.
                  if (cmd_q && pre_q != 2'h3)
                  begin
                     pre_q <= pre_q + 2'h1;
                     // Lock and unlock end after the third byte.
                     if (pre_q == 2'h2 && op_q != pep_pkg::OP_WRITE)
                        pre_q <= 2'h3;
                     else if (pre_q == 2'h2)
                     begin
                        a_q <= a_q;
                        pre_q <= 2'h3;
                     end
                  end
                  else
                     busy_q <= fin_q; // Busy on after the last byte.
                  last_d_q <= d_q;
               end
            pep_pkg::ST_POLL_RD:
               if (t_zero)
               begin
                  rdat_q <= pin_d;
                  cs_q <= 1'b1;
                  oe_q <= 1'b1;
                  t_q <= pep_pkg::CNT_W'(pep_pkg::DF_CYC + 2);
               end
            pep_pkg::ST_POLL_FLOAT:
               if (t_zero && !(poll_match || wc_over))
               begin
                  cs_q <= 1'b0;
                  oe_q <= 1'b0;
                  t_q <= pep_pkg::CNT_W'(pep_pkg::ACC_CYC + 2);
               end
            pep_pkg::ST_DONE:
            begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               fin_q <= 1'b0;
            end
            default: ;
         endcase
      end
   end

   // Read data buffer: a stalled reader never loses a byte.
   pep_buf2 #(.W(pep_pkg::DATA_W)) u_buf (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(rdat_q),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   // Pin and status outputs come straight from flops.
   assign chip_sel_n = cs_q;
   assign out_gate_n = oe_q;
   assign wr_strobe_n = we_q;
   assign mem_addr = a_q;
   assign mem_data_out = d_q;
   assign mem_data_oe = doe_q;
   assign busy = busy_q;
   assign prog_done = done_q;
   assign page_error = perr_q;

   // Checks beside the logic.
   a_gate_wr_high: assert property (@(posedge clk) disable iff (!rst_n)
      !we_q |-> oe_q) else $error("gate low during write strobe");
   a_drive_wr: assert property (@(posedge clk) disable iff (!rst_n)
      doe_q |-> oe_q) else $error("data driven with gate low");
   a_write_sel: assert property (@(posedge clk) disable iff (!rst_n)
      !we_q |-> !cs_q && doe_q) else $error("strobe without select");
   a_page_fixed: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(we_q) && inpage_q && !cmd_q |-> a_q[pep_pkg::ADDR_W-1:PAGE_LO_W] == page_q)
      else $error("page bits moved");
   a_cmd_addr: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(we_q) && cmd_q && pre_q != 2'h3 |-> a_q[pep_pkg::ADDR_W-1:pep_pkg::CMD_ADDR_W] == '0)
      else $error("command address high bits");
   a_window_kept: assert property (@(posedge clk) disable iff (!rst_n)
      inpage_q |-> wc_q < pep_pkg::CNT_W'(BLC_CYCLES)) else $error("byte window overrun");
   a_float_read: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(oe_q) && !doe_q |-> ##1 oe_q) else $error("gate pulse too short");
   a_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      done_q |-> !busy_q ##1 !done_q) else $error("done not a pulse");
   c_read: cover property (@(posedge clk) rd_valid && rd_ready);
   c_page: cover property (@(posedge clk) inpage_q && $fell(we_q));
   c_done: cover property (@(posedge clk) done_q);
   c_stall: cover property (@(posedge clk) rd_valid && !rd_ready && !buf_in_ready);
endmodule : pep_host
`default_nettype wire

// ### inc/pep_pkg.sv
/*
 Package for the paged EEPROM host controller: pin widths, timing
 figures in their own units with derived cycle counts, command codes.
 Assumes a 100 MHz system clock.
*/
package pep_pkg;
   localparam int CLK_MHZ = 100;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int CMD_ADDR_W = 15;
   localparam int PAGE_LO = 8;
   localparam int POLL_BIT = 7;
   localparam int PAGE_BYTES = 256;
   // Times as printed, in ns, us or ms.
   localparam int T_ACC_NS = 200;
   localparam int T_WP_NS = 100;
   localparam int T_WPH_NS = 50;
   localparam int T_AH_NS = 50;
   localparam int T_DF_NS = 55;
   localparam int T_BLC_US = 150;
   localparam int T_WC_MS = 10;
   // Times in ns round up to whole cycles; times in us and ms scale exactly.
   localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
   localparam int DF_CYC = (T_DF_NS * CLK_MHZ + 999) / 1000;
   localparam int BLC_CYC = T_BLC_US * CLK_MHZ;
   localparam int WC_CYC = T_WC_MS * 1000 * CLK_MHZ;
   localparam int CNT_W = 24;
   // Command prefix for the write lock feature (values are a plain choice).
   localparam logic [CMD_ADDR_W-1:0] CMD_A0 = 15'h5555;
   localparam logic [CMD_ADDR_W-1:0] CMD_A1 = 15'h2aaa;
   localparam logic [CMD_ADDR_W-1:0] CMD_A2 = 15'h5555;
   localparam logic [DATA_W-1:0] CMD_D0 = 8'haa;
   localparam logic [DATA_W-1:0] CMD_D1 = 8'h55;
   localparam logic [DATA_W-1:0] CMD_LOCK = 8'ha0;
   localparam logic [DATA_W-1:0] CMD_UNLOCK_D3 = 8'h80;
   // Request opcodes.
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_LOCK = 2'h2;
   localparam logic [1:0] OP_UNLOCK = 2'h3;
   typedef enum logic [3:0] {
      ST_IDLE, ST_RD_WAIT, ST_RD_FLOAT, ST_WR_SETUP, ST_WR_LOW, ST_WR_HIGH,
      ST_POLL_RD, ST_POLL_FLOAT, ST_DONE
   } pep_state_t;
endpackage : pep_pkg

// ### src/pep_buf2.sv
/*
 Two-entry valid/ready buffer in flip-flops, indexed by pointers.
 Assumes both sides run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pep_buf2 #(
   parameter int W = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem_q [2];
   logic wp_q, rp_q;
   logic [1:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // Full and empty come straight from the occupancy count.
   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rp_q];
   // Pointers and count advance on each handshake.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            mem_q[wp_q] <= in_data;
            wp_q <= ~wp_q;
         end
         if (pop)
            rp_q <= ~rp_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : pep_buf2
`default_nettype wire

// ### dv/pep_mem_model.sv
/*
 Behavioural model of the byte-wide paged memory behind the host
 controller: read, float, page load, byte window, self-timed programming,
 polling and the write lock feature.
 Assumes it is timed by the bench clock and sampled on its falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module pep_mem_model #(
   parameter int BLC = 200,
   parameter int WC = 500
) (
   // Timing clock.
   input wire logic clk,
   // Pins from the host.
   input wire logic chip_sel_n,
   input wire logic out_gate_n,
   input wire logic wr_strobe_n,
   input wire logic [pep_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [pep_pkg::DATA_W-1:0] host_data,
   input wire logic host_oe,
   // Resolved data byte.
   output logic [pep_pkg::DATA_W-1:0] mem_data_in
);
   logic [7:0] mem [int];
   logic [18:0] pa [$];
   logic [7:0] pd [$];
   logic lock_q = 1'b0;
   logic act = 1'b0;
   logic act_q = 1'b0;
   logic [18:0] la = 19'h00000;
   logic [7:0] ld = 8'h00;
   logic [7:0] last_d = 8'h00;
   logic [7:0] out_q = 8'h00;
   int win = 0;
   int prog = 0;
   int faults = 0;
   wire rd_en = !chip_sel_n && !out_gate_n && wr_strobe_n;
   // The host wins the wire while it drives; otherwise the model's byte.
   assign mem_data_in = host_oe ? host_data : out_q;

   function automatic logic [7:0] rd_mem(input logic [18:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : a[7:0] ^ 8'h5a;
   endfunction : rd_mem

   // Decide at the end of programming what the load meant.
   task automatic commit();
      logic pre;
      int f;
      pre = pa.size() >= 3 && pa[0][14:0] == pep_pkg::CMD_A0 && pd[0] == pep_pkg::CMD_D0 &&
         pa[1][14:0] == pep_pkg::CMD_A1 && pd[1] == pep_pkg::CMD_D1 &&
         pa[2][14:0] == pep_pkg::CMD_A2;
      f = pre ? 3 : 0;
      if (pre && pd[2] == pep_pkg::CMD_UNLOCK_D3)
         lock_q = 1'b0;
      else if (pre && pd[2] == pep_pkg::CMD_LOCK)
         lock_q = 1'b1;
      if (pa.size() - f > 256)
         faults++;
      for (int k = f; k < pa.size(); k++)
      begin
         if ((pre && pd[2] == pep_pkg::CMD_LOCK) || (!pre && !lock_q))
         begin
            if (pa[k][18:8] != pa[f][18:8])
               faults++;
            mem[int'(pa[k])] = pd[k];
         end
      end
      pa.delete();
      pd.delete();
   endtask : commit

   // Sampled on the falling edge so the host's registered pins have settled.
   always @(negedge clk)
   begin
      act = !chip_sel_n && !wr_strobe_n && out_gate_n;
      if (!chip_sel_n && !wr_strobe_n && !out_gate_n)
         faults++;
      if (rd_en && host_oe)
         faults++;
      // A released line toggles, so a stale byte can never pass as data.
      if (rd_en)
         out_q <= (prog > 0 || win > 0) ? {~last_d[7], last_d[6:0]} : rd_mem(mem_addr);
      else
         out_q <= ~out_q;
      if (act && !act_q)
         la = mem_addr;
      if (act)
         ld = mem_data_in;
      if (act_q && !act && prog == 0)
      begin
         pa.push_back(la);
         pd.push_back(ld);
         last_d = ld;
         win = BLC;
      end
      else if (win > 0)
      begin
         win--;
         if (win == 0)
            prog = WC;
      end
      else if (prog > 0)
      begin
         prog--;
         if (prog == 0)
            commit();
      end
      act_q = act;
   end
endmodule : pep_mem_model
`default_nettype wire

// ### dv/paged_parallel_eeprom_port_bench.sv
/*
 Self-checking bench for the paged memory host controller.
 Assumes the memory model in pep_mem_model and a 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module paged_parallel_eeprom_port_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic req_last = 1'b0;
   logic rd_ready = 1'b0;
   logic [1:0] req_op = 2'h0;
   logic [18:0] req_addr = 19'h00000;
   logic [7:0] req_wdata = 8'h00;
   wire logic req_ready, rd_valid, busy, prog_done, page_error, cs_n, og_n, ws_n, d_oe;
   wire logic [18:0] m_addr;
   wire logic [7:0] rd_data, d_out, d_in;
   int err_count = 0;
   int checks_done = 0;
   int rr_mode = 0;
   logic [31:0] rs = 32'h00000029;
   logic [31:0] rr_s = 32'h00000029;
   logic [7:0] exp_q [$];
   logic [7:0] ref_m [int];

   pep_host #(.BLC_CYCLES(200), .WC_CYCLES(2000)) i_pep_host (.clk(clk), .rst_n(rst_n),
      .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_last(req_last), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .busy(busy), .prog_done(prog_done), .page_error(page_error),
      .chip_sel_n(cs_n), .out_gate_n(og_n), .wr_strobe_n(ws_n), .mem_addr(m_addr),
      .mem_data_in(d_in), .mem_data_out(d_out), .mem_data_oe(d_oe));
   pep_mem_model #(.BLC(200), .WC(500)) i_pep_mem_model (.clk(clk), .chip_sel_n(cs_n),
      .out_gate_n(og_n), .wr_strobe_n(ws_n), .mem_addr(m_addr), .host_data(d_out),
      .host_oe(d_oe), .mem_data_in(d_in));

   initial
   begin
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, want, seen);
      end
   endtask : chk

   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   // Hold the request until the edge where ready is seen high.
   task automatic send(input logic [1:0] op, input logic [18:0] a, input logic [7:0] d,
      input logic l);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_wdata <= d;
      req_last <= l;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 8000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 8000)
      begin
         err_count++;
         results();
      end
      @(posedge clk);
      req_valid <= 1'b0;
   endtask : send

   task automatic rd(input logic [18:0] a);
      exp_q.push_back(ref_m.exists(int'(a)) ? ref_m[int'(a)] : a[7:0] ^ 8'h5a);
      send(pep_pkg::OP_READ, a, 8'h00, 1'b0);
   endtask : rd

   task automatic wait_done();
      int n;
      n = 0;
      while (prog_done !== 1'b1 && n < 4000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 4000)
      begin
         err_count++;
         results();
      end
   endtask : wait_done

   // Read side: steady, stalled, or randomly stalling receiver.
   always @(posedge clk)
   begin
      rr_s = xs(rr_s);
      rd_ready <= (rr_mode == 2) || (rr_mode == 1 && rr_s[0]);
   end

   // Each delivered byte is matched against the oldest noted expectation.
   always @(negedge clk)
   begin
      if (rst_n && rd_valid === 1'b1 && rd_ready === 1'b1)
         chk("rd_data", rd_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
   end

   initial
   begin
      logic [10:0] pg;
      logic [18:0] a;
      int cnt;
      int n;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rr_mode = 2;
      @(negedge clk);
      chk("idle_pins", {cs_n, og_n, ws_n, d_oe, busy, rd_valid}, 6'h38);
      // Page loads of one byte closed by the window, a full page, a short page.
      for (int s = 0; s < 3; s++)
      begin
         cnt = (s == 0) ? 1 : (s == 1) ? 256 : 5;
         rs = xs(rs);
         pg = rs[18:8];
         for (int k = 0; k < cnt; k++)
         begin
            rs = xs(rs);
            a = {pg, 8'(k * 37)};
            ref_m[int'(a)] = rs[7:0];
            send(pep_pkg::OP_WRITE, a, rs[7:0], s > 0 && k == cnt - 1);
         end
         wait_done();
         chk("page_error", page_error, 0);
         rr_mode = 1;
         for (int k = 0; k < cnt; k++)
            rd({pg, 8'(k * 37 + 1)});
         for (int k = 0; k < cnt; k++)
            rd({pg, 8'(k * 37)});
      end
      // Lock, write under the lock, then unlock.
      for (int s = 0; s < 2; s++)
      begin
         send(s ? pep_pkg::OP_UNLOCK : pep_pkg::OP_LOCK, 19'h00000, 8'h00, 1'b1);
         wait_done();
         chk("lock", i_pep_mem_model.lock_q, s ? 0 : 1);
         a = {11'h3c1 + 11'(s), 8'h40};
         ref_m[int'(a)] = 8'h81 + 8'(s);
         send(pep_pkg::OP_WRITE, a, 8'h81 + 8'(s), 1'b1);
         wait_done();
         rd(a);
      end
      // Stall the receiver until the buffer refuses, then drain it.
      n = 0;
      while (exp_q.size() > 0 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      chk("pre_drained", exp_q.size(), 0);
      rr_mode = 0;
      rd(19'h00012);
      rd(19'h00113);
      repeat (80) @(posedge clk);
      @(negedge clk);
      chk("rd_valid_held", rd_valid, 1);
      chk("req_ready_full", req_ready, 0);
      rr_mode = 1;
      n = 0;
      while (exp_q.size() > 0 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      chk("drained", exp_q.size(), 0);
      chk("faults", i_pep_mem_model.faults, 0);
      results();
   end
endmodule : paged_parallel_eeprom_port_bench
`default_nettype wire
